/* logic/eep_host_ctrl.sv */
// Notes on behaviour
// - A read drives chip select and output gate both low and only then samples the data pins.
// - No write starts while strobe or chip select is high or output gate low; idle pins hold that.
// - With address bit nine at high voltage, addresses 7E0 to 7FF reach the identification row.
// - High voltage on output gate with strobe and chip select low sets the main array to ones.
`timescale 1ns/1ps
`include "eep_params.svh"

module eep_host_ctrl
    import eep_pkg::*;
#(
    parameter int WC_CYCLES = `EEP_T_WC_NS / `EEP_CLK_NS
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // AXI4-Lite slave
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Interrupt
    output logic                        irq,
    // Device pins
    output logic [`EEP_ADDR_W-1:0]      memAddr,
    output logic                        chipSelN,
    output logic                        outGateN,
    output logic                        writeStrobeN,
    output logic                        addrBitNineHv,
    output logic                        outGateHv,
    input  wire logic [7:0]             dataIn,
    output logic [7:0]                  dataOut,
    output logic                        dataOe,
    input  wire logic                   readyBusy
);

    localparam int READ_CYC  = `EEP_CYC(`EEP_T_ACC_NS);
    localparam int FLOAT_CYC = `EEP_CYC(`EEP_T_OFF_NS);
    localparam int AS_CYC    = `EEP_CYC(`EEP_T_AS_NS);
    localparam int WPL_CYC   = `EEP_CYC(`EEP_T_WPL_NS);
    localparam int DH_CYC    = `EEP_CYC(`EEP_T_DH_NS);
    localparam int DB_CYC    = `EEP_CYC(`EEP_T_DB_NS);

    function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                                input logic [31:0] nw,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    eep_state_e                 state_ff;
    logic [31:0]                cnt_ff;
    logic [7:0]                 rdData_ff;
    logic                       doneEv_ff;
    logic                       tmoEv_ff;
    logic                       awHeld_ff;
    logic                       wHeld_ff;
    logic [7:0]                 awAddr_ff;
    logic [31:0]                wData_ff;
    logic [3:0]                 wStrb_ff;
    logic [31:0]                ctrl_ff;
    logic [31:0]                addrReg_ff;
    logic [31:0]                wdataReg_ff;
    logic [1:0]                 istat_ff;
    logic [1:0]                 imask_ff;
    logic                       doWr;
    logic                       go;
    eep_op_e                    goOp;
    logic [31:0]                ctrlNew;
    logic [31:0]                istatW1c;
    logic [31:0]                imaskNew;

    assign doWr     = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    assign ctrlNew  = byte_merge(ctrl_ff, wData_ff, wStrb_ff);
    assign go       = doWr && (awAddr_ff == `EEP_OFF_CTRL) && ctrlNew[`EEP_CTRL_START];
    assign goOp     = eep_op_e'(ctrlNew[`EEP_CTRL_OP_HI:`EEP_CTRL_OP_LO]);
    assign istatW1c = (doWr && awAddr_ff == `EEP_OFF_ISTAT) ?
                      byte_merge(32'h0000_0000, wData_ff, wStrb_ff) : 32'h0000_0000;
    assign imaskNew = byte_merge({30'h0, imask_ff}, wData_ff, wStrb_ff);

    // Write channels: address and data taken independently, response after both
    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld_ff     <= 1'b0;
            wHeld_ff      <= 1'b0;
            awAddr_ff     <= 8'h00;
            wData_ff      <= 32'h0000_0000;
            wStrb_ff      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `EEP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff     <= 1'b1;
                awAddr_ff     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!awHeld_ff) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff     <= 1'b1;
                wData_ff     <= s_axi_wdata;
                wStrb_ff     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!wHeld_ff) begin
                s_axi_wready <= 1'b1;
            end
            if (doWr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr_ff > `EEP_OFF_IMASK || awAddr_ff[1:0] != 2'h0) ?
                                `EEP_RESP_SLVERR : `EEP_RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHeld_ff    <= 1'b0;
                wHeld_ff     <= 1'b0;
            end
        end
    end

    // Software registers; a start bit never stays set
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff     <= 32'h0000_0000;
            addrReg_ff  <= 32'h0000_0000;
            wdataReg_ff <= 32'h0000_0000;
            imask_ff    <= 2'h0;
        end else if (doWr) begin
            case (awAddr_ff)
                `EEP_OFF_CTRL: begin
                    ctrl_ff                 <= ctrlNew & 32'h0000_000E;
                end
                `EEP_OFF_ADDR:  addrReg_ff  <= byte_merge(addrReg_ff, wData_ff, wStrb_ff);
                `EEP_OFF_WDATA: wdataReg_ff <= byte_merge(wdataReg_ff, wData_ff, wStrb_ff);
                `EEP_OFF_IMASK: imask_ff    <= imaskNew[1:0];
                default: ;
            endcase
        end
    end

    // Sticky events; a new event wins over a write-one-to-clear
    always_ff @(posedge clk) begin
        if (rst) begin
            istat_ff <= 2'h0;
            irq      <= 1'b0;
        end else begin
            istat_ff <= (istat_ff & ~istatW1c[1:0]) | {tmoEv_ff, doneEv_ff};
            irq      <= |(istat_ff & imask_ff);
        end
    end

    // Read channel
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `EEP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `EEP_RESP_OKAY;
            case (s_axi_araddr)
                `EEP_OFF_CTRL:   s_axi_rdata <= ctrl_ff;
                `EEP_OFF_ADDR:   s_axi_rdata <= addrReg_ff & 32'h0000_07FF;
                `EEP_OFF_WDATA:  s_axi_rdata <= wdataReg_ff & 32'h0000_00FF;
                `EEP_OFF_STATUS: s_axi_rdata <= {16'h0000, rdData_ff, 6'h00, readyBusy,
                                                 state_ff != EEP_IDLE};
                `EEP_OFF_ISTAT:  s_axi_rdata <= {30'h0, istat_ff};
                `EEP_OFF_IMASK:  s_axi_rdata <= {30'h0, imask_ff};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `EEP_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Device pin sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff      <= EEP_IDLE;
            cnt_ff        <= 32'h0000_0000;
            chipSelN      <= 1'b1;
            outGateN      <= 1'b1;
            writeStrobeN  <= 1'b1;
            addrBitNineHv <= 1'b0;
            outGateHv     <= 1'b0;
            dataOe        <= 1'b0;
            dataOut       <= 8'h00;
            memAddr       <= '0;
            rdData_ff     <= 8'h00;
            doneEv_ff     <= 1'b0;
            tmoEv_ff      <= 1'b0;
        end else begin
            doneEv_ff <= 1'b0;
            tmoEv_ff  <= 1'b0;
            cnt_ff    <= cnt_ff + 32'h0000_0001;
            case (state_ff)
                EEP_IDLE: begin
                    cnt_ff <= 32'h0000_0000;
                    if (go && readyBusy && goOp != EEP_OP_NONE) begin
                        addrBitNineHv <= ctrlNew[`EEP_CTRL_XROW];
                        memAddr       <= ctrlNew[`EEP_CTRL_XROW] ?
                                         (`EEP_XROW_BASE | {6'h00, addrReg_ff[4:0]}) :
                                         addrReg_ff[`EEP_ADDR_W-1:0];
                        chipSelN      <= 1'b0;
                        if (goOp == EEP_OP_READ) begin
                            outGateN <= 1'b0;
                            state_ff <= EEP_RD_WAIT;
                        end else begin
                            outGateN  <= 1'b1;
                            outGateHv <= (goOp == EEP_OP_CLEAR);
                            dataOe    <= (goOp == EEP_OP_WRITE);
                            dataOut   <= wdataReg_ff[7:0];
                            state_ff  <= EEP_WR_SETUP;
                        end
                    end
                end
                EEP_RD_WAIT: begin
                    if (cnt_ff == 32'(READ_CYC - 1)) begin
                        rdData_ff <= dataIn;
                        chipSelN  <= 1'b1;
                        outGateN  <= 1'b1;
                        cnt_ff    <= 32'h0000_0000;
                        state_ff  <= EEP_RD_FLOAT;
                    end
                end
                EEP_RD_FLOAT: begin
                    if (cnt_ff == 32'(FLOAT_CYC - 1)) begin
                        addrBitNineHv <= 1'b0;
                        doneEv_ff     <= 1'b1;
                        state_ff      <= EEP_IDLE;
                    end
                end
                EEP_WR_SETUP: begin
                    if (cnt_ff == 32'(AS_CYC - 1)) begin
                        writeStrobeN <= 1'b0;
                        cnt_ff       <= 32'h0000_0000;
                        state_ff     <= EEP_WR_PULSE;
                    end
                end
                EEP_WR_PULSE: begin
                    if (cnt_ff == 32'(WPL_CYC - 1)) begin
                        writeStrobeN <= 1'b1;
                        cnt_ff       <= 32'h0000_0000;
                        state_ff     <= EEP_WR_HOLD;
                    end
                end
                EEP_WR_HOLD: begin
                    if (cnt_ff == 32'(DH_CYC - 1)) begin
                        chipSelN      <= 1'b1;
                        dataOe        <= 1'b0;
                        outGateHv     <= 1'b0;
                        addrBitNineHv <= 1'b0;
                        cnt_ff        <= 32'h0000_0000;
                        state_ff      <= EEP_WAIT_BUSY;
                    end
                end
                EEP_WAIT_BUSY: begin
                    // Ready/busy may not have fallen yet; ignore it for the busy delay
                    if (cnt_ff == 32'(DB_CYC - 1)) begin
                        state_ff <= EEP_WAIT_READY;
                    end
                end
                EEP_WAIT_READY: begin
                    if (readyBusy) begin
                        doneEv_ff <= 1'b1;
                        state_ff  <= EEP_IDLE;
                    end else if (cnt_ff >= 32'(WC_CYCLES)) begin
                        tmoEv_ff  <= 1'b1;
                        state_ff  <= EEP_IDLE;
                    end
                end
                default: state_ff <= EEP_IDLE;
            endcase
        end
    end

    read_gate_a: assert property (@(posedge clk) disable iff (rst)
        dataOe |-> outGateN)
        else $error("data driven while output gate low");

    read_sample_a: assert property (@(posedge clk) disable iff (rst)
        state_ff == EEP_RD_WAIT |-> !chipSelN && !outGateN && !dataOe)
        else $error("read without both selects low");

    standby_idle_a: assert property (@(posedge clk) disable iff (rst)
        state_ff == EEP_IDLE |-> chipSelN && writeStrobeN && !dataOe)
        else $error("idle pins not in standby");

    strobe_width_a: assert property (@(posedge clk) disable iff (rst)
        $fell(writeStrobeN) |-> !writeStrobeN [*5] ##1 writeStrobeN)
        else $error("write strobe width wrong");

    write_inhibit_a: assert property (@(posedge clk) disable iff (rst)
        !writeStrobeN |-> !chipSelN && outGateN)
        else $error("strobe low with write inhibited");

    addr_hold_a: assert property (@(posedge clk) disable iff (rst)
        !writeStrobeN && !$past(writeStrobeN) |-> $stable(memAddr) && $stable(dataOut))
        else $error("address moved during strobe");

    data_latch_a: assert property (@(posedge clk) disable iff (rst)
        $rose(writeStrobeN) && !outGateHv |-> dataOe && !chipSelN)
        else $error("data or select gone at strobe rise");

    busy_strobe_a: assert property (@(posedge clk) disable iff (rst)
        state_ff == EEP_WAIT_READY && !readyBusy |=> writeStrobeN [*2])
        else $error("strobe while device busy");

    xrow_addr_a: assert property (@(posedge clk) disable iff (rst)
        addrBitNineHv |-> memAddr >= `EEP_XROW_BASE && memAddr <= `EEP_XROW_HI)
        else $error("extra row outside 7E0..7FF");

    clear_pins_a: assert property (@(posedge clk) disable iff (rst)
        outGateHv && !writeStrobeN |-> !chipSelN && !dataOe && outGateN)
        else $error("chip clear pins wrong");

    irq_level_a: assert property (@(posedge clk) disable iff (rst)
        ##1 irq == |($past(istat_ff) & $past(imask_ff)))
        else $error("interrupt level mismatch");

endmodule

/* inc/eep_params.svh */
`ifndef EEP_PARAMS_SVH
`define EEP_PARAMS_SVH

// Clock and least-time to cycle conversion (rounds up)
`define EEP_CLK_NS          20
`define EEP_CYC(ns)         (((ns) + `EEP_CLK_NS - 1) / `EEP_CLK_NS)

// Device timing, in ns
`define EEP_T_ACC_NS        150
`define EEP_T_OFF_NS        50
`define EEP_T_AS_NS         10
`define EEP_T_WPL_NS        100
`define EEP_T_DH_NS         10
`define EEP_T_DB_NS         50
`define EEP_T_WC_NS         1000000

// Device geometry
`define EEP_ADDR_W          11
`define EEP_XROW_BASE       11'h7E0
`define EEP_XROW_HI         11'h7FF

// Register byte offsets
`define EEP_OFF_CTRL        8'h00
`define EEP_OFF_ADDR        8'h04
`define EEP_OFF_WDATA       8'h08
`define EEP_OFF_STATUS      8'h0C
`define EEP_OFF_ISTAT       8'h10
`define EEP_OFF_IMASK       8'h14

// Control register fields
`define EEP_CTRL_START      0
`define EEP_CTRL_OP_LO      1
`define EEP_CTRL_OP_HI      2
`define EEP_CTRL_XROW       3

// Interrupt status fields
`define EEP_IRQ_DONE        0
`define EEP_IRQ_TMO         1

// Bus responses
`define EEP_RESP_OKAY       2'h0
`define EEP_RESP_SLVERR     2'h2

`endif

/* inc/eep_pkg.sv */
package eep_pkg;

    typedef enum logic [2:0] {
        EEP_IDLE,
        EEP_RD_WAIT,
        EEP_RD_FLOAT,
        EEP_WR_SETUP,
        EEP_WR_PULSE,
        EEP_WR_HOLD,
        EEP_WAIT_BUSY,
        EEP_WAIT_READY
    } eep_state_e;

    typedef enum logic [1:0] {
        EEP_OP_READ,
        EEP_OP_WRITE,
        EEP_OP_CLEAR,
        EEP_OP_NONE
    } eep_op_e;

endpackage

/* test/eep_dev_model.sv */
`timescale 1ns/1ps

module eep_dev_model (
    // Device pins
    input  wire logic [10:0] memAddr,
    input  wire logic        chipSelN,
    input  wire logic        outGateN,
    input  wire logic        writeStrobeN,
    input  wire logic        addrBitNineHv,
    input  wire logic        outGateHv,
    // Host data drive and supply state
    input  wire logic [7:0]  hostData,
    input  wire logic        hostOe,
    input  wire logic        vccLow,
    // Resolved lines
    output logic [7:0]       busLevel,
    output logic             readyBusy
);
    logic [7:0]  mainMem [2048];
    logic [7:0]  xrowMem [32];
    logic [7:0]  devVal, lastDrv, floatVal, latD, lastWr;
    logic [10:0] latA, lastA;
    logic        latX, lastX, busy, isX, devDrv, latClr;
    int          wcNs = 3000;
    realtime     fallT;

    initial begin
        busy = 1'b0;
        lastDrv = 8'h00;
        floatVal = 8'hFF;
        for (int i = 0; i < 2048; i++) mainMem[i] = 8'(i) ^ 8'h5A;
        for (int i = 0; i < 32; i++) xrowMem[i] = 8'(i) ^ 8'hC3;
    end
    assign isX = addrBitNineHv && memAddr >= 11'h7E0;
    assign devDrv = !chipSelN && !outGateN;
    always_comb begin
        devVal = isX ? xrowMem[memAddr[4:0]] : mainMem[memAddr];
        if (busy && memAddr == lastA && isX == lastX) begin
            devVal = {~lastWr[7], ~devVal[6:0]};
        end
    end
    // Released lines show the inverse of the last driven byte
    always @(hostOe, devDrv, hostData, devVal) begin
        if (hostOe) lastDrv = hostData;
        else if (devDrv) lastDrv = devVal;
        else floatVal = ~lastDrv;
    end
    assign busLevel = hostOe ? hostData : (devDrv ? devVal : floatVal);
    assign readyBusy = !busy;
    always @(negedge writeStrobeN) begin
        fallT = $realtime;
        if (!busy) begin
            latA = memAddr;
            latX = isX;
        end
    end
    always @(posedge writeStrobeN) begin
        if (!busy && !chipSelN && (outGateN || outGateHv) && !vccLow
            && ($realtime - fallT) >= 10.0) begin
            latD = hostData;
            // The high-voltage gate is gone long before the timer ends, so latch it
            latClr = outGateHv;
            lastA = latA;
            lastX = latX;
            lastWr = latD;
            busy = 1'b1;
            fork
                begin
                    if (!latClr && !latX) mainMem[latA] = 8'hFF;
                    #(wcNs);
                    if (latClr) foreach (mainMem[i]) mainMem[i] = 8'hFF;
                    else if (latX) xrowMem[latA[4:0]] = latD;
                    else mainMem[latA] = latD;
                    busy = 1'b0;
                end
            join_none
        end
    end
endmodule

/* test/eep_host_ctrl_tb.sv */
`timescale 1ns/1ps
`include "eep_params.svh"

module eep_host_ctrl_tb;
    logic        clk, rst, vccLow;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, dataIn, dataOut;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdData, ist;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, lastResp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        irq, chipSelN, outGateN, writeStrobeN, addrBitNineHv, outGateHv;
    logic        dataOe, readyBusy;
    logic [10:0] memAddr, a;
    logic [7:0]  d, shadow [2048], shadowX [32];
    int          n_errors, compares;

    eep_host_ctrl #(.WC_CYCLES(200)) uut (.*);
    eep_dev_model dev (.memAddr(memAddr), .chipSelN(chipSelN), .outGateN(outGateN),
        .writeStrobeN(writeStrobeN), .addrBitNineHv(addrBitNineHv), .outGateHv(outGateHv),
        .hostData(dataOut), .hostOe(dataOe), .vccLow(vccLow), .busLevel(dataIn),
        .readyBusy(readyBusy));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [7:0] initByte(input int i, input logic x);
        return 8'(i) ^ (x ? 8'hC3 : 8'h5A);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic axiWr(input logic [7:0] ad, input logic [31:0] wd);
        bit awDone, wDone;
        awDone = 0;
        wDone = 0;
        s_axi_awaddr <= ad;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clk);
            if (s_axi_awready && !awDone) begin
                awDone = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !wDone) begin
                wDone = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!s_axi_bvalid);
        // Ready stays high between calls, so it never toggles twice in one step
        lastResp = s_axi_bresp;
    endtask
    task automatic axiRd(input logic [7:0] ad);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        rdData = s_axi_rdata;
        lastResp = s_axi_rresp;
    endtask
    task automatic runOp(input logic [1:0] op, input logic [10:0] ad, input logic [7:0] wd,
                         input logic x);
        int k;
        axiWr(`EEP_OFF_ADDR, {21'h0, ad});
        axiWr(`EEP_OFF_WDATA, {24'h0, wd});
        axiWr(`EEP_OFF_CTRL, {28'h0, x, op, 1'b1});
        for (k = 0; k < 3000 && !irq; k++) @(posedge clk);
        axiRd(`EEP_OFF_ISTAT);
        ist = rdData;
        axiWr(`EEP_OFF_ISTAT, ist);
    endtask
    task automatic readByte(input logic [10:0] ad, input logic x);
        runOp(2'h0, ad, 8'h00, x);
        axiRd(`EEP_OFF_STATUS);
    endtask
    task automatic finish_test;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        #1_000_000;
        n_errors++;
        finish_test;
    end

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, vccLow} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        rst = 1'b1;
        void'($urandom(32'he8d2));
        for (int i = 0; i < 2048; i++) shadow[i] = initByte(i, 1'b0);
        for (int i = 0; i < 32; i++) shadowX[i] = initByte(i, 1'b1);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        axiRd(`EEP_OFF_STATUS);
        check(rdData[1:0], 2'b10, "idle status");
        axiRd(8'h20);
        check(lastResp, `EEP_RESP_SLVERR, "unmapped");
        axiWr(8'h20, 32'h0000_0000);
        check(lastResp, `EEP_RESP_SLVERR, "unmapped write");
        axiWr(`EEP_OFF_IMASK, 32'h0000_0003);
        check(lastResp, `EEP_RESP_OKAY, "write okay");
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7FF : 11'($urandom);
            d = 8'($urandom);
            runOp(2'h1, a, d, 1'b0);
            check(ist, 32'h1, "write done");
            shadow[a] = d;
            readByte(a, 1'b0);
            check(rdData[15:8], shadow[a], "read back");
        end
        $display("test byte write done");
        d = 8'($urandom);
        runOp(2'h1, 11'h005, d, 1'b1);
        shadowX[5] = d;
        readByte(11'h005, 1'b1);
        check(rdData[15:8], shadowX[5], "extra row");
        readByte(11'h7E5, 1'b0);
        check(rdData[15:8], shadow[11'h7E5], "main under row");
        $display("test extra row done");
        runOp(2'h2, 11'h000, 8'h00, 1'b0);
        check(ist, 32'h1, "clear done");
        a = 11'($urandom);
        readByte(a, 1'b0);
        check(rdData[15:8], 8'hFF, "cleared");
        readByte(11'h005, 1'b1);
        check(rdData[15:8], shadowX[5], "row kept");
        $display("test chip clear done");
        vccLow <= 1'b1;
        runOp(2'h1, 11'h003, 8'h00, 1'b0);
        vccLow <= 1'b0;
        readByte(11'h003, 1'b0);
        check(rdData[15:8], 8'hFF, "low supply");
        $display("test supply done");
        axiWr(`EEP_OFF_IMASK, 32'h0000_0000);
        axiWr(`EEP_OFF_CTRL, 32'h0000_0001);
        repeat (20) @(posedge clk);
        check(irq, 1'b0, "masked irq");
        axiRd(`EEP_OFF_ISTAT);
        check(rdData, 32'h1, "sticky done");
        axiWr(`EEP_OFF_IMASK, 32'h0000_0001);
        repeat (3) @(posedge clk);
        check(irq, 1'b1, "unmasked irq");
        axiWr(`EEP_OFF_ISTAT, 32'h0000_0001);
        repeat (3) @(posedge clk);
        check(irq, 1'b0, "cleared irq");
        axiWr(`EEP_OFF_IMASK, 32'h0000_0003);
        $display("test interrupt done");
        dev.wcNs = 6000;
        d = 8'($urandom);
        runOp(2'h1, 11'h009, d, 1'b0);
        check(ist, 32'h2, "timeout");
        for (int k = 0; k < 1000 && !readyBusy; k++) @(posedge clk);
        dev.wcNs = 3000;
        readByte(11'h009, 1'b0);
        check(rdData[15:8], d, "slow write");
        $display("test slow device done");
        finish_test;
    end
endmodule
